// *** hdl/adccal_pkg.sv ***
package adccal_pkg;
  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [3:0]  DUAL_EDGE_ENABLE_OFS   = 4'hD;
  localparam int          DUAL_EDGE_ENABLE_W     = 16;
  localparam int          AUTO_PHASE_BIT         = 14;
  localparam logic [15:0] DUAL_EDGE_ENABLE_RST   = 16'h0000;
  // ****************************************************************
  // timing counts, in input clock cycles, and the counter width in bits
  // ****************************************************************
  localparam int          QUAL_CYCLES            = 640;
  localparam int          SHORT_DELAY_CYCLES     = 16777216;
  localparam int          LONG_DELAY_CYCLES      = 1073741824;
  localparam int          CAL_RUN_CYCLES         = 1400000;
  localparam int          SYNC_STAGES            = 2;
  localparam int          CNT_W                  = 31;
  // ****************************************************************
  // sequencer states
  // ****************************************************************
  typedef enum logic [2:0] {
    ADCCAL_POR_WAIT = 3'b000,
    ADCCAL_DELAY    = 3'b001,
    ADCCAL_IDLE     = 3'b010,
    ADCCAL_START    = 3'b011,
    ADCCAL_RUN      = 3'b100
  } adccal_state_e;
endpackage : adccal_pkg

// *** hdl/adccal_sync.sv ***
`timescale 1ns/1ps
// two-flop synchroniser for one pin level
module adccal_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic i_core_clk,
  input  wire logic i_sys_rst,
  input  wire logic i_async,
  output logic      o_sync
);
  logic meta_reg;
  logic sync_reg;

  // first stage is read only by the second stage
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      meta_reg <= RST_VAL;
      sync_reg <= RST_VAL;
    end else begin
      meta_reg <= i_async;
      sync_reg <= meta_reg;
    end
  end
  assign o_sync = sync_reg;
endmodule : adccal_sync

// *** hdl/adccal_ctrl.sv ***
`timescale 1ns/1ps
// Operation
// - calibrate after power-up and again on each valid command request
// - calibration_active high exactly while a calibration runs
// - output data clock held idle during calibration
// - power-on calibration waits a delay picked by delay select
// - request high at power-up skips power-on calibration
// - without sample clock at power-up analog stays powered down
// - request is 640 cycles low then 640 high; shorter ignored
// - calibration begins 640 cycles after the qualified rising edge
// - delay select chooses between exactly two delay lengths
// - power-down high at power-up holds the delay counter
// - extended control mode always uses the short delay
// - edge select high gives rising-edge data change, low falling
// - dual-edge routes one input to both converters, other disabled
// - floating delay pin in pin mode gives I-input dual-edge, short
// - power-down raised mid calibration waits until it finishes
// - calibration requests during power-down are ignored entirely
module adccal_ctrl
  import adccal_pkg::*;
#(
  parameter int SHORT_DELAY = SHORT_DELAY_CYCLES,
  parameter int LONG_DELAY  = LONG_DELAY_CYCLES,
  parameter int CAL_CYCLES  = CAL_RUN_CYCLES
) (
  input  wire logic                          i_core_clk,
  input  wire logic                          i_sys_rst,
  input  wire logic                          i_calibrate_request,
  input  wire logic                          i_calibration_delay_select,
  input  wire logic                          i_delay_pin_floating,
  input  wire logic                          i_power_down_pin,
  input  wire logic                          i_output_edge_select,
  input  wire logic                          i_extended_mode,
  input  wire logic                          i_ext_dual_edge_en,
  input  wire logic                          i_ext_dual_edge_q_in,
  input  wire logic                          i_reg_wr,
  input  wire logic [3:0]                    i_reg_addr,
  input  wire logic [DUAL_EDGE_ENABLE_W-1:0] i_reg_wdata,
  output logic      [DUAL_EDGE_ENABLE_W-1:0] o_reg_rdata,
  output logic                               o_calibration_active,
  output logic                               o_output_data_clock_enable,
  output logic                               o_data_on_rising,
  output logic                               o_analog_power_down,
  output logic                               o_dual_edge_sampling,
  output logic                               o_route_i_to_both,
  output logic                               o_route_q_to_both,
  output logic                               o_auto_phase_enable
);
  import adccal_pkg::*;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic cal_s;
  logic pd_s;
  logic dly_s;
  logic flt_s;
  logic edge_s;
  logic ext_s;

  adccal_sync #(.RST_VAL(1'b0)) u_sync_cal (.i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst), .i_async(i_calibrate_request),
    .o_sync(cal_s));
  adccal_sync #(.RST_VAL(1'b0)) u_sync_pd (.i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst), .i_async(i_power_down_pin), .o_sync(pd_s));
  adccal_sync #(.RST_VAL(1'b0)) u_sync_dly (.i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst), .i_async(i_calibration_delay_select),
    .o_sync(dly_s));
  adccal_sync #(.RST_VAL(1'b0)) u_sync_flt (.i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst), .i_async(i_delay_pin_floating),
    .o_sync(flt_s));
  adccal_sync #(.RST_VAL(1'b0)) u_sync_edge (.i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst), .i_async(i_output_edge_select),
    .o_sync(edge_s));
  adccal_sync #(.RST_VAL(1'b0)) u_sync_ext (.i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst), .i_async(i_extended_mode), .o_sync(ext_s));

  // ****************************************************************
  // request qualifier
  // ****************************************************************
  // low_ok: request has been low for the full count since last change
  logic [9:0] qcnt_reg, qcnt_next;
  logic       last_reg, last_next;
  logic       low_ok_reg, low_ok_next;
  logic       cal_go;
  logic       in_pd;

  // counter restarts on every level change so glitches never qualify
  always_comb begin
    last_next   = cal_s;
    qcnt_next   = qcnt_reg;
    low_ok_next = low_ok_reg;
    cal_go      = 1'b0;
    if (cal_s != last_reg) begin
      // the changed cycle is the first one of the new level
      qcnt_next = 10'h001;
    end else if (qcnt_reg != 10'(QUAL_CYCLES - 1)) begin
      qcnt_next = qcnt_reg + 10'h001;
    end else if (!cal_s) begin
      low_ok_next = 1'b1;
    end else if (low_ok_reg) begin
      low_ok_next = 1'b0;
      cal_go      = !in_pd;
    end
    // a high phase that ends early spends the qualified low phase
    if (!cal_s && last_reg) begin
      low_ok_next = 1'b0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      qcnt_reg   <= 10'h000;
      last_reg   <= 1'b0;
      low_ok_reg <= 1'b0;
    end else begin
      qcnt_reg   <= qcnt_next;
      last_reg   <= last_next;
      low_ok_reg <= low_ok_next;
    end
  end

  // ****************************************************************
  // calibration sequencer
  // ****************************************************************
  adccal_state_e    state_reg, state_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic             por_seen_reg, por_seen_next;
  logic             short_sel;
  logic [CNT_W-1:0] delay_len;

  // extended mode or floating pin forces the short delay
  assign short_sel = ext_s || flt_s || !dly_s;
  assign delay_len = short_sel ? CNT_W'(SHORT_DELAY - 1)
                               : CNT_W'(LONG_DELAY - 1);
  assign in_pd     = pd_s && (state_reg != ADCCAL_RUN);

  always_comb begin
    state_next    = state_reg;
    cnt_next      = cnt_reg;
    por_seen_next = por_seen_reg;
    unique case (state_reg)
      ADCCAL_POR_WAIT: begin
        // strap read only once the synchroniser holds the real pin level
        if (cnt_reg == CNT_W'(SYNC_STAGES)) begin
          por_seen_next = 1'b1;
          cnt_next      = '0;
          state_next    = cal_s ? ADCCAL_IDLE : ADCCAL_DELAY;
        end else begin
          cnt_next = cnt_reg + CNT_W'(1);
        end
      end
      ADCCAL_DELAY: begin
        if (cal_go) begin
          state_next = ADCCAL_START;
        end else if (!pd_s) begin
          // delay counter frozen while power-down is held
          if (cnt_reg >= delay_len) begin
            state_next = ADCCAL_START;
          end else begin
            cnt_next = cnt_reg + CNT_W'(1);
          end
        end
      end
      ADCCAL_IDLE: begin
        if (cal_go) begin
          state_next = ADCCAL_START;
        end
      end
      ADCCAL_START: begin
        cnt_next   = '0;
        state_next = ADCCAL_RUN;
      end
      ADCCAL_RUN: begin
        // power-down is not honoured until the run ends
        if (cnt_reg == CNT_W'(CAL_CYCLES - 1)) begin
          state_next = ADCCAL_IDLE;
        end else begin
          cnt_next = cnt_reg + CNT_W'(1);
        end
      end
      default: state_next = ADCCAL_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      state_reg    <= ADCCAL_POR_WAIT;
      cnt_reg      <= '0;
      por_seen_reg <= 1'b0;
    end else begin
      state_reg    <= state_next;
      cnt_reg      <= cnt_next;
      por_seen_reg <= por_seen_next;
    end
  end

  // ****************************************************************
  // mode register and outputs
  // ****************************************************************
  logic [DUAL_EDGE_ENABLE_W-1:0] de_reg, de_next;
  logic                          active_reg, active_next;
  logic                          rise_reg, rise_next;
  logic                          pdn_reg, pdn_next;
  logic                          des_reg, des_next;
  logic                          rti_reg, rti_next;
  logic                          rtq_reg, rtq_next;

  // outputs registered except the readback mux and the data clock and auto-phase enable gates; the analog powers down until clocking proves out
  always_comb begin
    de_next = de_reg;
    if (i_reg_wr && i_reg_addr == DUAL_EDGE_ENABLE_OFS) begin
      de_next = i_reg_wdata;
    end
    active_next = (state_next == ADCCAL_RUN);
    rise_next   = edge_s;
    pdn_next    = !por_seen_next || (pd_s && state_next != ADCCAL_RUN);
    des_next    = ext_s ? i_ext_dual_edge_en : flt_s;
    rti_next    = des_next && !(ext_s && i_ext_dual_edge_q_in);
    rtq_next    = des_next && ext_s && i_ext_dual_edge_q_in;
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      de_reg     <= DUAL_EDGE_ENABLE_RST;
      active_reg <= 1'b0;
      rise_reg   <= 1'b0;
      pdn_reg    <= 1'b1;
      des_reg    <= 1'b0;
      rti_reg    <= 1'b0;
      rtq_reg    <= 1'b0;
    end else begin
      de_reg     <= de_next;
      active_reg <= active_next;
      rise_reg   <= rise_next;
      pdn_reg    <= pdn_next;
      des_reg    <= des_next;
      rti_reg    <= rti_next;
      rtq_reg    <= rtq_next;
    end
  end

  assign o_reg_rdata          = (i_reg_addr == DUAL_EDGE_ENABLE_OFS)
                                ? de_reg : '0;
  assign o_calibration_active = active_reg;
  assign o_output_data_clock_enable        = !active_reg && !pdn_reg;
  assign o_data_on_rising     = rise_reg;
  assign o_analog_power_down  = pdn_reg;
  assign o_dual_edge_sampling = des_reg;
  assign o_route_i_to_both    = rti_reg;
  assign o_route_q_to_both    = rtq_reg;
  assign o_auto_phase_enable  = des_reg && ext_s && de_reg[AUTO_PHASE_BIT];

  // ****************************************************************
  // checks
  // ****************************************************************
  // request run lengths counted apart from the qualifier, saturating
  logic [10:0] chk_hi_reg, chk_hi_next;
  logic [10:0] chk_lo_reg, chk_lo_next;

  always_comb begin
    chk_hi_next = 11'h000;
    chk_lo_next = chk_lo_reg;
    if (cal_s && chk_hi_reg != 11'h7FF) begin
      chk_hi_next = chk_hi_reg + 11'h001;
    end else if (cal_s) begin
      chk_hi_next = chk_hi_reg;
    end
    if (!cal_s && chk_hi_reg != 11'h000) begin
      chk_lo_next = 11'h001;
    end else if (!cal_s && chk_lo_reg != 11'h7FF) begin
      chk_lo_next = chk_lo_reg + 11'h001;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      chk_hi_reg <= 11'h000;
      chk_lo_reg <= 11'h000;
    end else begin
      chk_hi_reg <= chk_hi_next;
      chk_lo_reg <= chk_lo_next;
    end
  end

  sequence s_start_run;
    (state_reg == ADCCAL_START) ##1 active_reg;
  endsequence
  property p_active_state;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      active_reg == (state_reg == ADCCAL_RUN);
  endproperty
  a_active_state: assert property (p_active_state)
    else $error("active flag missing while running");
  property p_output_data_clock_off;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      active_reg |-> !o_output_data_clock_enable;
  endproperty
  a_output_data_clock_off: assert property (p_output_data_clock_off)
    else $error("data clock enabled during calibration");
  property p_short_pulse;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      cal_go |-> cal_s && chk_hi_reg >= 11'(QUAL_CYCLES - 1)
                 && chk_lo_reg >= 11'(QUAL_CYCLES);
  endproperty
  a_short_pulse: assert property (p_short_pulse)
    else $error("short pulse started calibration");
  property p_go_start;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (cal_go && state_reg == ADCCAL_IDLE) |=> s_start_run;
  endproperty
  a_go_start: assert property (p_go_start)
    else $error("request did not start calibration");
  property p_pd_ignore;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      in_pd |-> !cal_go;
  endproperty
  a_pd_ignore: assert property (p_pd_ignore)
    else $error("request honoured in power down");
  property p_pd_hold;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (state_reg == ADCCAL_DELAY && pd_s && !cal_go) |=>
        $stable(cnt_reg);
  endproperty
  a_pd_hold: assert property (p_pd_hold)
    else $error("delay counter ran in power down");
  property p_run_pd;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (state_reg == ADCCAL_RUN && cnt_reg != CNT_W'(CAL_CYCLES - 1))
        |=> state_reg == ADCCAL_RUN;
  endproperty
  a_run_pd: assert property (p_run_pd)
    else $error("calibration cut short");
  property p_edge;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      ##1 o_data_on_rising == $past(edge_s);
  endproperty
  a_edge: assert property (p_edge)
    else $error("edge select not followed");
  property p_short_ext;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (ext_s || flt_s) |-> delay_len == CNT_W'(SHORT_DELAY - 1);
  endproperty
  a_short_ext: assert property (p_short_ext)
    else $error("long delay used in extended or float mode");
endmodule : adccal_ctrl

// *** verif/adccal_host.sv ***
`timescale 1ns/1ps
// ****************************************************************
// host model driving the calibrate pin
// ****************************************************************
module adccal_host (
  input  wire logic i_core_clk,
  output logic      o_calibrate_request
);
  initial o_calibrate_request = 1'b0;
  // low phase then high phase, counted in input clock cycles
  // requests are only issued in normal mode, never in dual-edge
  task automatic pulse(input int lo, input int hi);
    o_calibrate_request = 1'b0;
    repeat (lo) @(negedge i_core_clk);
    o_calibrate_request = 1'b1;
    repeat (hi) @(negedge i_core_clk);
  endtask : pulse
  // strap level held before reset release, steady across it
  task automatic strap(input logic lvl);
    o_calibrate_request = lvl;
  endtask : strap
endmodule : adccal_host

// *** verif/adccal_ctrl_tb.sv ***
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
  miscompares++; $display("Error %s exp %0h got %0h", n, e, g); end end
module adccal_ctrl_tb;
  import adccal_pkg::*;
  localparam int S = 50;
  localparam int L = 100;
  localparam int C = 30;
  logic        clk = 1'b0, rst = 1'b1, cal, dsel = 1'b0, flt = 1'b0;
  logic        pd = 1'b0, oes = 1'b0, ext = 1'b0, xen = 1'b0, xq = 1'b0;
  logic        wr = 1'b0, bad;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wdata = 16'h0000, rd, rv;
  logic        act, output_data_clock, rise, apd, des, ri, rq, aph;
  int          miscompares = 0, comparisons = 0, n, m;
  always #2 clk = ~clk;
  adccal_host adccal_host_inst (.i_core_clk(clk), .o_calibrate_request(cal));
  adccal_ctrl #(.SHORT_DELAY(S), .LONG_DELAY(L), .CAL_CYCLES(C))
  adccal_ctrl_inst (
    .i_core_clk(clk), .i_sys_rst(rst), .i_calibrate_request(cal),
    .i_calibration_delay_select(dsel), .i_delay_pin_floating(flt),
    .i_power_down_pin(pd), .i_output_edge_select(oes),
    .i_extended_mode(ext), .i_ext_dual_edge_en(xen),
    .i_ext_dual_edge_q_in(xq), .i_reg_wr(wr), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .o_reg_rdata(rd), .o_calibration_active(act),
    .o_output_data_clock_enable(output_data_clock), .o_data_on_rising(rise),
    .o_analog_power_down(apd), .o_dual_edge_sampling(des),
    .o_route_i_to_both(ri), .o_route_q_to_both(rq),
    .o_auto_phase_enable(aph));
  // ****************************************************************
  // pin and register tasks, all driven at the falling edge
  // ****************************************************************
  // straps are set before reset so they are steady at its release
  task automatic por(input logic s, x, f, c, p);
    @(negedge clk);
    rst = 1'b1; dsel = s; ext = x; flt = f; pd = p;
    adccal_host_inst.strap(c);
    repeat (4) @(negedge clk);
    rst = 1'b0;
  endtask : por
  // cycles until calibration starts, lim if it never does
  // completion is only ever learnt from the active flag
  task automatic wait_act(input int lim, output int k);
    for (k = 0; k < lim && act !== 1'b1; k++) @(negedge clk);
  endtask : wait_act
  // length of the running phase, flagging any live output clock
  task automatic run_len(output int k);
    bad = 1'b0;
    for (k = 0; k < 4 * C && act === 1'b1; k++) begin
      if (output_data_clock !== 1'b0) bad = 1'b1;
      @(negedge clk);
    end
  endtask : run_len
  task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
    wr = 1'b1; addr = a; wdata = d;
    @(negedge clk);
    wr = 1'b0;
  endtask : reg_write
  // readback is combinational; take it one settled cycle later
  task automatic reg_read(input logic [3:0] a, output logic [15:0] d);
    addr = a;
    @(negedge clk);
    d = rd;
  endtask : reg_read
  task automatic stop_test;
    if (miscompares == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test
  // ****************************************************************
  // scenarios
  // ****************************************************************
  initial begin
    por(0, 0, 0, 0, 0);
    `CHK("apd_in_reset", 1'b1, apd)
    repeat (3) @(negedge clk);
    `CHK("apd_after", 1'b0, apd)
    wait_act(400, n);
    `CHK("por_short", 1'b1, n >= S - 3 && n <= S + 8)
    run_len(m);
    `CHK("cal_len", C, m)
    `CHK("output_data_clock_idle", 1'b0, bad)
    por(1, 0, 0, 0, 0);
    wait_act(400, n);
    `CHK("por_long", 1'b1, n >= L - 3 && n <= L + 8)
    por(1, 1, 0, 0, 0);
    wait_act(400, n);
    `CHK("por_ext", 1'b1, n >= S - 3 && n <= S + 8)
    por(1, 0, 0, 0, 0);
    flt = 1'b1; // pin held high through power-up, floated after
    wait_act(400, n);
    `CHK("por_float", 1'b1, n >= S - 3 && n <= S + 8)
    `CHK("des_float", 1'b1, des && ri && !rq)
    // strap high: no power-on run, then a full request
    por(0, 0, 0, 1, 0);
    wait_act(L + 50, n);
    `CHK("strap_skip", L + 50, n)
    adccal_host_inst.pulse(640, 0); // later recalibration on command
    wait_act(700, n);
    `CHK("cmd_start", 1'b1, n >= 640 && n <= 648)
    run_len(m);
    `CHK("cmd_len", C, m)
    // short high phase, then short low phase: both dropped
    adccal_host_inst.pulse(640, 300);
    adccal_host_inst.pulse(300, 0);
    wait_act(800, n);
    `CHK("short_pulse", 800, n)
    // power-down held at power-up freezes the delay count
    por(0, 0, 0, 0, 1);
    repeat (200) @(negedge clk);
    pd = 1'b0;
    wait_act(400, n);
    `CHK("pd_hold", 1'b1, n >= S - 3 && n <= S + 8)
    run_len(m);
    pd = 1'b1;
    adccal_host_inst.pulse(640, 700);
    pd = 1'b0;
    wait_act(800, n);
    `CHK("pd_req", 800, n)
    // power-down raised mid-run waits for the end of the run
    adccal_host_inst.pulse(640, 0);
    wait_act(700, n);
    pd = 1'b1;
    run_len(m);
    `CHK("pd_midrun", C, m)
    `CHK("pd_output_data_clock", 1'b0, output_data_clock)
    pd = 1'b0;
    for (int i = 0; i < 2; i++) begin
      oes = i[0];
      repeat (4) @(negedge clk);
      `CHK("edge_sel", oes, rise)
    end
    // register: reset value, write, unmapped read, phase enable
    reg_read(DUAL_EDGE_ENABLE_OFS, rv);
    `CHK("reg_rst", DUAL_EDGE_ENABLE_RST, rv)
    ext = 1'b1; xen = 1'b1; xq = 1'b1;
    reg_write(DUAL_EDGE_ENABLE_OFS, 16'h4000);
    reg_read(DUAL_EDGE_ENABLE_OFS, rv);
    `CHK("reg_wr", 16'h4000, rv)
    reg_read(4'h3, rv);
    `CHK("reg_unmapped", 16'h0000, rv)
    repeat (4) @(negedge clk);
    `CHK("ext_q", 1'b1, des && rq && !ri)
    `CHK("auto_phase", 1'b1, aph)
    reg_write(DUAL_EDGE_ENABLE_OFS, 16'h0000);
    `CHK("phase_off", 1'b0, aph)
    stop_test();
  end
  // watchdog: the scenarios take well under 25000 cycles
  initial begin
    #100000;
    miscompares++;
    stop_test();
  end
endmodule : adccal_ctrl_tb
